// ---- src/sync_serial_pkg.sv ----
// constants, mode codes and state type of the synchronous serial port
// Functional notes
// - port works only while enable is set
// - pin directions follow master or slave role
// - opposite direction bit suppresses that pin function
// - shift on programmed edge, capture on other
// - master starts a byte when buffer written
// - receive-only master shifts in one byte per buffer write
// - master clock from divide 4/16/64 or timer
// - bytes travel most significant bit first
// - edge bit set: data valid before first edge
// - slave shifts on master clock, flags last bit
// - slave flags after eight bits, wakes only with interrupts enabled
// - select gating only in select slave mode
// - select high floats data-out at once
// - select high or disable clears shift logic
// - data-out as input stops transmission
// - master completion wakes only with interrupts enabled
// - sleep pauses master transfer, resumes afterwards
// - reset disables port and aborts transfer
// - standard modes map to polarity and edge
// - polarity bit picks serial clock idle level
// - full byte goes to buffer, flags set
// - write while shifting ignored, sets collision flag
// - reading the last buffered byte clears the buffer-full flag
package sync_serial_pkg;

   localparam int unsigned MODE_W        = 4;
   localparam logic [3:0]  MODE_MDIV4    = 4'h0;
   localparam logic [3:0]  MODE_MDIV16   = 4'h1;
   localparam logic [3:0]  MODE_MDIV64   = 4'h2;
   localparam logic [3:0]  MODE_MTMR2    = 4'h3;
   localparam logic [3:0]  MODE_SLV_SS   = 4'h4;
   localparam logic [3:0]  MODE_SLV_NOSS = 4'h5;

   // half bit periods in system clocks for the dividers
   localparam logic [5:0]  HALF_DIV4     = 6'h02;
   localparam logic [5:0]  HALF_DIV16    = 6'h08;
   localparam logic [5:0]  HALF_DIV64    = 6'h20;
   localparam logic [5:0]  HALF_ONE      = 6'h01;

   localparam logic [3:0]  EDGE_LAST     = 4'hf;
   localparam logic [2:0]  BIT_LAST      = 3'h7;
   localparam logic [7:0]  SR_RST        = 8'h00;
   localparam logic [2:0]  PIN_RST       = 3'h4;

   localparam int unsigned BUF_DEPTH     = 2;
   localparam logic [1:0]  BUF_FULL_CNT  = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_PUSH = 3'b100
   } mst_state_e;

endpackage

// ---- src/byte_stream_if.sv ----
// byte stream with valid and ready between the port and its receive buffer
interface byte_stream_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ---- src/sync_serial_rxbuf.sv ----
// two-entry receive buffer between shift logic and software reads
module sync_serial_rxbuf (
   // clock and reset
   input  wire logic   sys_clk_i,
   input  wire logic   nrst_i,
   // streams
   byte_stream_if.snk  in_s,
   byte_stream_if.src  out_s
);
   import sync_serial_pkg::*;

   logic [7:0] mem_q [BUF_DEPTH];
   logic       wr_q;
   logic       rd_q;
   logic [1:0] cnt_q;
   logic       push;
   logic       pop;

   assign in_s.ready  = (cnt_q != BUF_FULL_CNT);
   assign out_s.valid = (cnt_q != 2'h0);
   assign out_s.data  = mem_q[rd_q];
   assign push        = in_s.valid & in_s.ready;
   assign pop         = out_s.valid & out_s.ready;

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_s.data;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         wr_q  <= wr_q ^ push;
         rd_q  <= rd_q ^ pop;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   chk_full_refuse: assert property (cnt_q == BUF_FULL_CNT && !pop |=> cnt_q == BUF_FULL_CNT && $stable(wr_q))
      else $error("buffer accepts a byte while full");
   chk_read_clears_full: assert property ((cnt_q == 2'h1) && pop && !push |=> !out_s.valid)
      else $error("full flag stays set after last byte read");
endmodule

// ---- src/sync_serial_port.sv ----
// four-wire serial port: master and slave shifting, flags and receive buffer
module sync_serial_port (
   // clock and reset
   input  wire logic                               sys_clk_i,
   input  wire logic                               nrst_i,
   // control bits
   input  wire logic                               port_enable_bit_i,
   input  wire logic                               clock_polarity_bit_i,
   input  wire logic                               clock_edge_bit_i,
   input  wire logic [sync_serial_pkg::MODE_W-1:0] port_mode_field_i,
   // pin direction bits, one means input
   input  wire logic                               sck_dir_i,
   input  wire logic                               sdi_dir_i,
   input  wire logic                               sdo_dir_i,
   input  wire logic                               ss_dir_i,
   // transfer buffer access
   input  wire logic                               buf_wr_i,
   input  wire logic [7:0]                         buf_wdata_i,
   input  wire logic                               buf_rd_i,
   output      logic [7:0]                         buf_rdata_o,
   output      logic                               buffer_full_flag_o,
   // flags and power control
   input  wire logic                               write_collision_flag_clr_i,
   output      logic                               write_collision_flag_o,
   input  wire logic                               ovf_clr_i,
   output      logic                               overflow_flag_o,
   input  wire logic                               irq_clr_i,
   output      logic                               port_irq_flag_o,
   input  wire logic                               irq_enable_i,
   output      logic                               wake_o,
   input  wire logic                               sleep_i,
   output      logic                               busy_o,
   // timer tick for the timer clock source
   input  wire logic                               tmr2_tick_i,
   // serial pins
   input  wire logic                               sck_i,
   output      logic                               sck_o,
   output      logic                               sck_oe_o,
   input  wire logic                               sdi_i,
   output      logic                               sdo_o,
   output      logic                               sdo_oe_o,
   input  wire logic                               ss_n_i
);
   import sync_serial_pkg::*;

   // receive path between shift logic and buffer
   byte_stream_if rx_in ();
   byte_stream_if rx_out ();

   // pin synchronisers: ss_n, sdi, sck
   logic [2:0] pin_raw;
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] sync3_q;
   logic [2:0] agree;
   logic [2:0] filt_d;
   logic [2:0] filt_q;
   logic       sck_f;
   logic       sdi_f;
   logic       ss_n_f;
   logic       sck_prev_q;
   logic       ss_prev_q;

   assign pin_raw = {ss_n_i, sdi_i, sck_i};
   assign agree   = ~(sync2_q ^ sync3_q);
   assign filt_d  = (filt_q & ~agree) | (sync3_q & agree);
   assign sck_f   = filt_q[0];
   assign sdi_f   = filt_q[1];
   assign ss_n_f  = filt_q[2];

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_q    <= PIN_RST;
         sync2_q    <= PIN_RST;
         sync3_q    <= PIN_RST;
         filt_q     <= PIN_RST;
         sck_prev_q <= 1'b0;
         ss_prev_q  <= 1'b1;
      end else begin
         sync1_q    <= pin_raw;
         sync2_q    <= sync1_q;
         sync3_q    <= sync2_q;
         filt_q     <= filt_d;
         sck_prev_q <= sck_f;
         ss_prev_q  <= ss_n_f;
      end
   end

   // mode decode
   logic is_master;
   logic is_slave;
   logic use_tmr2;
   logic ss_ctl;
   logic ss_high;
   logic ss_rise;
   logic port_clr;
   logic sck_listen;
   logic sdi_bit;

   assign is_master  = port_enable_bit_i & (port_mode_field_i <= MODE_MTMR2);
   assign is_slave   = port_enable_bit_i & ((port_mode_field_i == MODE_SLV_SS) |
                                            (port_mode_field_i == MODE_SLV_NOSS));
   assign use_tmr2   = (port_mode_field_i == MODE_MTMR2);
   assign ss_ctl     = is_slave & (port_mode_field_i == MODE_SLV_SS) & ss_dir_i;
   assign ss_high    = ss_ctl & ss_n_f;
   assign ss_rise    = ss_high & ~ss_prev_q;
   assign port_clr   = ~port_enable_bit_i | ss_rise;
   assign sck_listen = is_slave & sck_dir_i;
   assign sdi_bit    = sdi_dir_i & sdi_f;

   // master clock generation
   mst_state_e st_q;
   mst_state_e st_d;
   logic [5:0] half_lim;
   logic [5:0] hc_q;
   logic [3:0] ec_q;
   logic       act_q;
   logic       hc_wrap;
   logic       m_step;
   logic       m_lead;
   logic       m_trail;

   assign half_lim = (port_mode_field_i == MODE_MDIV16) ? HALF_DIV16 :
                     (port_mode_field_i == MODE_MDIV64) ? HALF_DIV64 : HALF_DIV4;
   assign hc_wrap  = (hc_q == half_lim - HALF_ONE);
   assign m_step   = (st_q == ST_RUN) & ~sleep_i & (use_tmr2 ? tmr2_tick_i : hc_wrap);
   assign m_lead   = m_step & ~act_q;
   assign m_trail  = m_step & act_q;

   // master capture waits out the pin filter delay on data-in
   logic [3:0] cap_pipe_q;
   logic       m_cap;
   logic       m_pend;

   assign m_cap  = is_master & (clock_edge_bit_i ? m_lead : m_trail);
   assign m_pend = (cap_pipe_q != 4'h0);

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cap_pipe_q <= 4'h0;
      end else if (!is_master) begin
         cap_pipe_q <= 4'h0;
      end else begin
         cap_pipe_q <= {cap_pipe_q[2:0], m_cap};
      end
   end

   // slave clock edges from the filtered pin
   logic s_chg;
   logic s_lead;
   logic s_trail;
   logic lead;
   logic trail;
   logic cap_ev;
   logic shift_ev;

   assign s_chg    = sck_listen & ~port_clr & ~ss_high & (sck_f != sck_prev_q);
   assign s_lead   = s_chg & (sck_f != clock_polarity_bit_i);
   assign s_trail  = s_chg & (sck_f == clock_polarity_bit_i);
   assign lead     = is_master ? m_lead : s_lead;
   assign trail    = is_master ? m_trail : s_trail;
   assign cap_ev   = is_master ? cap_pipe_q[3] : (clock_edge_bit_i ? s_lead : s_trail);
   assign shift_ev = clock_edge_bit_i ? trail : lead;

   // shift register, bit count and data-out flop
   logic [7:0] sr_q;
   logic [7:0] tx_q;
   logic [2:0] bc_q;
   logic       out_q;
   logic       busy;
   logic       wr_ok;
   logic       wr_bad;
   logic       m_start;
   logic       m_done;
   logic       s_done;
   logic [7:0] rx_byte;

   assign busy    = (st_q != ST_IDLE) | (bc_q != 3'h0);
   assign wr_ok   = buf_wr_i & ~busy & (is_master | is_slave);
   assign wr_bad  = buf_wr_i & busy;
   assign m_start = wr_ok & is_master;
   assign m_done  = m_step & (ec_q == EDGE_LAST);
   assign s_done  = is_slave & cap_ev & (bc_q == BIT_LAST);
   assign rx_byte = {sr_q[6:0], sdi_bit};

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sr_q  <= SR_RST;
         tx_q  <= SR_RST;
         bc_q  <= 3'h0;
         out_q <= 1'b0;
      end else if (port_clr) begin
         sr_q  <= SR_RST;
         tx_q  <= SR_RST;
         bc_q  <= 3'h0;
         out_q <= 1'b0;
      end else if (wr_ok) begin
         sr_q  <= buf_wdata_i;
         tx_q  <= clock_edge_bit_i ? {buf_wdata_i[6:0], 1'b0} : buf_wdata_i;
         bc_q  <= 3'h0;
         out_q <= buf_wdata_i[7];
      end else begin
         if (cap_ev) begin
            sr_q  <= rx_byte;
            bc_q  <= bc_q + 3'h1;
         end
         if (shift_ev) begin
            out_q <= tx_q[7];
            tx_q  <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // master sequencing
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (m_start) begin
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (m_done) begin
               st_d = ST_PUSH;
            end
         end
         ST_PUSH: begin
            if (rx_in.ready & ~m_pend) begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      if (!is_master) begin
         st_d = ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hc_q <= 6'h00;
      end else if (st_q != ST_RUN) begin
         hc_q <= 6'h00;
      end else if (!sleep_i) begin
         hc_q <= hc_wrap ? 6'h00 : hc_q + 6'h01;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         act_q <= 1'b0;
         ec_q  <= 4'h0;
      end else if (st_q != ST_RUN) begin
         act_q <= 1'b0;
         ec_q  <= 4'h0;
      end else if (m_step) begin
         act_q <= ~act_q;
         ec_q  <= ec_q + 4'h1;
      end
   end

   // receive buffer
   logic push_fire;

   assign rx_in.valid  = ((st_q == ST_PUSH) & ~m_pend) | s_done;
   assign rx_in.data   = (st_q == ST_PUSH) ? sr_q : rx_byte;
   assign push_fire    = rx_in.valid & rx_in.ready;
   assign rx_out.ready = buf_rd_i;

   sync_serial_rxbuf u_rxbuf (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .in_s      (rx_in.snk),
      .out_s     (rx_out.src)
   );

   // sticky flags, set wins over clear
   logic write_collision_flag_q;
   logic ovf_q;
   logic irq_q;
   logic irq_set;

   assign irq_set = push_fire | s_done;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         write_collision_flag_q <= 1'b0;
         ovf_q  <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         write_collision_flag_q <= wr_bad | (write_collision_flag_q & ~write_collision_flag_clr_i);
         ovf_q  <= (s_done & ~rx_in.ready) | (ovf_q & ~ovf_clr_i);
         irq_q  <= irq_set | (irq_q & ~irq_clr_i);
      end
   end

   // outputs
   assign buf_rdata_o            = rx_out.data;
   assign buffer_full_flag_o     = rx_out.valid;
   assign write_collision_flag_o = write_collision_flag_q;
   assign overflow_flag_o        = ovf_q;
   assign port_irq_flag_o        = irq_q;
   assign wake_o                 = irq_set & irq_enable_i;
   assign busy_o                 = busy;
   assign sck_o                  = clock_polarity_bit_i ^ act_q;
   assign sck_oe_o               = is_master & ~sck_dir_i;
   assign sdo_o                  = out_q;
   assign sdo_oe_o               = (is_master | is_slave) & ~sdo_dir_i & ~(ss_ctl & ss_n_i);

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_accept_master;
      buf_wr_i && !busy && is_master;
   endsequence

   sequence s_accept_any;
      buf_wr_i && !busy && (is_master || is_slave);
   endsequence

   sequence s_sleep_run;
      (st_q == ST_RUN) && sleep_i;
   endsequence

   chk_master_start: assert property (s_accept_master |=> (st_q == ST_RUN) && !sck_oe_o == sck_dir_i)
      else $error("master did not start after buffer write");
   chk_first_bit_out: assert property (s_accept_any |=> sdo_o == $past(buf_wdata_i[7]))
      else $error("first data bit not presented after load");
   chk_collision_set: assert property (buf_wr_i && busy |=> write_collision_flag_o && busy_o)
      else $error("write during shift did not flag collision");
   chk_collision_keep: assert property (busy && buf_wr_i |=> $past(sr_q) == sr_q || $past(cap_ev))
      else $error("write during shift altered shift register");
   chk_sdo_float: assert property (ss_ctl && ss_n_i |-> !sdo_oe_o)
      else $error("data-out driven while select is high");
   chk_select_reset: assert property (ss_rise |=> sr_q == SR_RST && bc_q == 3'h0)
      else $error("select high did not clear shift logic");
   chk_select_gate: assert property (ss_high |-> !cap_ev && !shift_ev)
      else $error("slave shifted while select is high");
   chk_idle_level: assert property ((st_q == ST_IDLE) |-> sck_o == clock_polarity_bit_i)
      else $error("serial clock not at idle level");
   chk_sleep_pause: assert property (s_sleep_run |=> $stable(act_q) && $stable(ec_q) && $stable(hc_q))
      else $error("master advanced during sleep");
   chk_byte_flag: assert property (push_fire |=> port_irq_flag_o && buffer_full_flag_o)
      else $error("received byte did not set flags");
   chk_wake_gate: assert property (irq_set |-> wake_o == irq_enable_i)
      else $error("wake does not follow interrupt enable");
   chk_byte_edges: assert property ($rose(st_q == ST_PUSH) |-> $past(ec_q) == EDGE_LAST && !act_q)
      else $error("master byte not sixteen clock edges");
endmodule

// ---- testbench/spi_far_end.sv ----
// far-end controller model: answers as slave or drives the link as master
module spi_far_end (
   // clock and link setup
   input  wire logic sys_clk_i,
   input  wire logic pol_i,
   input  wire logic edge_i,
   // link from the port
   input  wire logic sck_i,
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i,
   // link to the port
   output logic      sck_o,
   output logic      ss_n_o,
   output logic      sdi_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] sh_q = 8'h00;
   logic [7:0] rx_q = 8'h00;
   logic       last_q = 1'b0;
   logic       slave_en = 1'b0;
   initial begin
      sck_o = 1'b0;
      ss_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   task automatic shift();
      sdi_o = sh_q[7];
      sh_q = {sh_q[6:0], 1'b0};
   endtask
   // a released data-out line reads as the inverse of its last level
   task automatic capture();
      last_q = sdo_oe_i ? sdo_i : ~last_q;
      rx_q = {rx_q[6:0], last_q};
   endtask
   task automatic load(input logic [7:0] tx);
      sh_q = tx;
      rx_q = 8'h00;
      if (edge_i) begin
         shift();
      end
   endtask
   task automatic lead();
      if (edge_i) capture(); else shift();
   endtask
   task automatic trail();
      if (edge_i) shift(); else capture();
   endtask
   always @(sck_i) begin
      if (slave_en) begin
         if (sck_i ^ pol_i) lead(); else trail();
      end
   end
   task automatic wt();
      repeat (8) @(posedge sys_clk_i);
      #1;
   endtask
   // clock stands at idle outside frames; high and low last 8 clocks
   task automatic master_xfer(input logic [7:0] tx, input int nbits, input logic sel);
      sck_o = pol_i;
      load(tx);
      ss_n_o = ~sel;
      wt();
      for (int k = 0; k < nbits; k++) begin
         sck_o = ~pol_i;
         lead();
         wt();
         sck_o = pol_i;
         trail();
         wt();
      end
      ss_n_o = 1'b1;
      wt();
   endtask
endmodule

// ---- testbench/sync_serial_port_bench.sv ----
// bench for the serial port: master, slave, collision, sleep and receive-only runs
module sync_serial_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import sync_serial_pkg::*;
   logic       sys_clk_i, nrst_i, en, pol, edg, sck_dir, sdi_dir, sdo_dir, ss_dir, wr, rd;
   logic       write_collision_flag_clr, ovf_clr, irq_clr, irq_en, sleep, tick2, wake_seen;
   logic [3:0] mode;
   logic [7:0] wdata, rdata;
   logic       full, write_collision_flag, ovf, irq, wake, busy, sck, sck_oe, serial_data_out_pin, sdo_oe, f_sck, f_ss_n, f_sdi;
   int         fails, tests_run, tcnt;
   sync_serial_port dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .port_enable_bit_i(en),
      .clock_polarity_bit_i(pol), .clock_edge_bit_i(edg), .port_mode_field_i(mode), .sck_dir_i(sck_dir),
      .sdi_dir_i(sdi_dir), .sdo_dir_i(sdo_dir), .ss_dir_i(ss_dir), .buf_wr_i(wr), .buf_wdata_i(wdata),
      .buf_rd_i(rd), .buf_rdata_o(rdata), .buffer_full_flag_o(full), .write_collision_flag_clr_i(write_collision_flag_clr),
      .write_collision_flag_o(write_collision_flag), .ovf_clr_i(ovf_clr), .overflow_flag_o(ovf), .irq_clr_i(irq_clr),
      .port_irq_flag_o(irq), .irq_enable_i(irq_en), .wake_o(wake), .sleep_i(sleep), .busy_o(busy),
      .tmr2_tick_i(tick2), .sck_i(f_sck), .sck_o(sck), .sck_oe_o(sck_oe), .sdi_i(f_sdi), .sdo_o(serial_data_out_pin),
      .sdo_oe_o(sdo_oe), .ss_n_i(f_ss_n));
   spi_far_end far (.sys_clk_i(sys_clk_i), .pol_i(pol), .edge_i(edg), .sck_i(sck_oe ? sck : pol),
      .sdo_i(serial_data_out_pin), .sdo_oe_i(sdo_oe), .sck_o(f_sck), .ss_n_o(f_ss_n), .sdi_o(f_sdi));
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      tcnt <= (tcnt + 1) % 3;
      tick2 <= (tcnt == 0);
      if (wake === 1'b1) wake_seen <= 1'b1;
   end
   task automatic tk(input int n = 1);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk1(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic cfg(input logic [3:0] m, input logic p, input logic e, input logic od);
      en = 1'b0;
      tk();
      mode = m;
      pol = p;
      edg = e;
      sdo_dir = od;
      sck_dir = (m >= MODE_SLV_SS);
      tk();
      en = 1'b1;
      tk(4);
   endtask
   task automatic pop(input logic [7:0] exp);
      for (int k = 0; k < 3000 && full !== 1'b1; k++) tk();
      chk1("buffer full", 1'b1, full);
      chk1("irq flag", 1'b1, irq);
      chk8("received byte", exp, rdata);
      rd = 1'b1;
      tk();
      rd = 1'b0;
      irq_clr = 1'b1;
      tk();
      irq_clr = 1'b0;
      chk1("buffer empty", 1'b0, full);
   endtask
   task automatic m_start(input logic [7:0] tx, input logic [7:0] ftx);
      far.load(ftx);
      far.slave_en = 1'b1;
      wake_seen = 1'b0;
      wr = 1'b1;
      wdata = tx;
      tk();
      wr = 1'b0;
   endtask
   task automatic m_finish(input logic [7:0] tx, input logic [7:0] ftx, input logic chk_far);
      pop(ftx);
      if (chk_far) chk8("far end byte", tx, far.rx_q);
      far.slave_en = 1'b0;
   endtask
   task automatic t_modes();
      for (int i = 0; i < 4; i++) begin
         cfg(i[3:0], i[1], ~i[0], 1'b0);
         chk1("sck idle", pol, sck);
         chk1("sck driven", 1'b1, sck_oe);
         m_start(8'ha5 ^ i[7:0], 8'h3c + i[7:0]);
         m_finish(8'ha5 ^ i[7:0], 8'h3c + i[7:0], 1'b1);
         chk1("wake seen", 1'b1, wake_seen);
      end
      irq_en = 1'b0;
      m_start(8'h0f, 8'hf0);
      m_finish(8'h0f, 8'hf0, 1'b1);
      chk1("no wake", 1'b0, wake_seen);
      irq_en = 1'b1;
      $display("test modes done");
   endtask
   task automatic t_collide();
      logic s;
      cfg(MODE_MDIV16, 1'b0, 1'b1, 1'b0);
      m_start(8'h81, 8'h42);
      tk(5);
      wr = 1'b1;
      wdata = 8'h7e;
      tk();
      wr = 1'b0;
      tk();
      chk1("collision", 1'b1, write_collision_flag);
      sleep = 1'b1;
      tk(2);
      s = sck;
      tk(40);
      chk1("sck paused", s, sck);
      chk1("busy paused", 1'b1, busy);
      sleep = 1'b0;
      m_finish(8'h81, 8'h42, 1'b1);
      chk1("collision sticky", 1'b1, write_collision_flag);
      write_collision_flag_clr = 1'b1;
      tk();
      write_collision_flag_clr = 1'b0;
      tk();
      chk1("collision cleared", 1'b0, write_collision_flag);
      $display("test collision done");
   endtask
   task automatic t_rxonly();
      cfg(MODE_MDIV4, 1'b0, 1'b1, 1'b1);
      chk1("sdo released", 1'b0, sdo_oe);
      m_start(8'h00, 8'h96);
      m_finish(8'h00, 8'h96, 1'b0);
      $display("test receive only done");
   endtask
   task automatic t_slave();
      cfg(MODE_SLV_SS, 1'b0, 1'b1, 1'b0);
      chk1("sck input", 1'b0, sck_oe);
      wr = 1'b1;
      wdata = 8'h5a;
      tk();
      wr = 1'b0;
      far.master_xfer(8'hc3, 8, 1'b1);
      pop(8'hc3);
      chk8("far end byte", 8'h5a, far.rx_q);
      far.master_xfer(8'hff, 3, 1'b1);
      chk1("sdo float", 1'b0, sdo_oe);
      chk1("count cleared", 1'b0, busy);
      cfg(MODE_SLV_NOSS, 1'b0, 1'b0, 1'b0);
      wr = 1'b1;
      wdata = 8'h6d;
      tk();
      wr = 1'b0;
      far.master_xfer(8'h24, 8, 1'b0);
      pop(8'h24);
      chk8("far end byte", 8'h6d, far.rx_q);
      $display("test slave done");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      {nrst_i, en, pol, edg, sck_dir, sdo_dir, wr, rd, write_collision_flag_clr, ovf_clr, irq_clr, sleep} = '0;
      {sdi_dir, ss_dir, irq_en} = 3'b111;
      mode = 4'h0;
      wdata = 8'h00;
      tcnt = 0;
      tick2 = 1'b0;
      wake_seen = 1'b0;
      fails = 0;
      tests_run = 0;
      tk(16);
      nrst_i = 1'b1;
      tk(2);
      chk1("reset full", 1'b0, full);
      chk1("reset irq", 1'b0, irq);
      chk1("reset busy", 1'b0, busy);
      chk1("reset sck", 1'b0, sck);
      t_modes();
      t_collide();
      t_rxonly();
      t_slave();
      give_verdict();
   end
   initial begin
      #600000;
      fails++;
      give_verdict();
   end
endmodule
